//--- rtl/mode_config_decode.sv
// mode-configuration register with burst, latency and recovery decode
//
// What this block does
// - mode_set_command with bank bits all zero loads the address word.
// - fields hold until next load; loop reset bit never persists.
// - loading the mode word never touches array data.
// - burst_size field picks four or eight for reads and writes.
// - burst stays in an aligned block and wraps inside it.
// - ordering_bit picks sequential or interleaved ordering.
// - sequential rotates low two bits, nibble by nibble.
// - interleaved visits start xor a rising counter.
// - test_mode_bit set: enter test mode, program nothing else.
// - loop_reset_bit pulses a loop reset and reads back as zero.
// - auto precharge starts recovery clocks after last write data.
// - exit_speed_bit selects fast or slow active power-down exit.
// - exit selection does not touch precharge power-down.
// - column_read_delay supports only 3, 4 or 5 clocks.
// - first read data at edge n plus read_latency for an early read; a plain read skips added latency.
// - early read is held added_latency clocks before execution.
// - command register adds one clock to read_latency.
// - read_latency is added plus column plus one; write_latency one less.
`timescale 1ns/1ps
module mode_config_decode
  import mode_cfg_pkg::*;
#(
  parameter int LOCK_WAIT = LOCK_CYCLES
)
(
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  input  wire logic              mode_set_command_in,
  input  wire logic [BANK_W-1:0] bank_in,
  input  wire logic [MODE_W-1:0] addr_in,
  input  wire logic [2:0]        added_latency_in,
  input  wire logic              read_cmd_in,
  input  wire logic              write_ap_cmd_in,
  input  wire logic              early_read_in,
  input  wire logic [2:0]        col_start_in,
  input  wire logic              active_pd_in,
  output logic      [MODE_W-1:0] load_mode_config_out,
  output logic      [2:0]        column_read_delay_out,
  output logic      [3:0]        read_latency_out,
  output logic      [3:0]        write_latency_out,
  output logic                   burst_eight_out,
  output logic                   interleaved_out,
  output logic      [2:0]        col_out,
  output logic                   burst_active_out,
  output logic                   loop_reset_out,
  output logic                   loop_locked_out,
  output logic                   read_data_out,
  output logic                   precharge_out,
  output logic                   test_mode_out,
  output logic                   slow_exit_out,
  output logic                   loop_frozen_out,
  output logic                   error_out
);

  // lock counter is twelve bits wide and must count at least once
  if (LOCK_WAIT < 1 || LOCK_WAIT > 4095)
  begin
    $error("LOCK_WAIT out of range");
  end

  //////////////////////////////////////////////////////////////////////
  // load decode

  mode_fields_t fields;
  mode_fields_t next_fields;

  wire sel_main = mode_set_command_in && (bank_in == '0);
  wire [2:0] f_burst = addr_in[BURST_LSB +: 3];
  wire [2:0] f_lat   = addr_in[LAT_LSB +: 3];
  wire [2:0] f_rec   = 3'(addr_in[REC_LSB +: 3] + 3'h1);
  wire burst_ok = (f_burst == BURST_CODE_4) || (f_burst == BURST_CODE_8);
  wire lat_ok   = (f_lat >= LAT_MIN) && (f_lat <= LAT_MAX);
  wire rec_ok   = (addr_in[REC_LSB +: 3] != 3'h0) &&
                  (f_rec >= REC_MIN) && (f_rec <= REC_MAX);
  wire test_req = addr_in[TEST_BIT];
  wire codes_ok = burst_ok && lat_ok && rec_ok;
  wire take     = sel_main && !test_req && codes_ok;

  always_comb
  begin
    next_fields.burst_eight       = (f_burst == BURST_CODE_8);
    next_fields.interleaved       = addr_in[ORDER_BIT];
    next_fields.column_read_delay = f_lat;
    next_fields.recovery          = f_rec;
    next_fields.slow_exit         = addr_in[EXIT_BIT];
  end

  // fields held, loop bit stored as zero; no array path
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      fields <= '{1'b0, 1'b0, RST_LAT, RST_REC, 1'b0};
      load_mode_config_out <= '0;
    end
    else if (take)
    begin
      fields <= next_fields;
      load_mode_config_out <= addr_in & ~(MODE_W'(1) << LOOP_RST_BIT);
    end
  end

  // test mode and error flags
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      test_mode_out <= 1'b0;
      error_out     <= 1'b0;
    end
    else if (sel_main)
    begin
      test_mode_out <= test_req;
      error_out     <= !test_req && !codes_ok;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // loop reset and lock holdoff

  logic [11:0] lock_cnt;
  wire loop_rst_req = take && addr_in[LOOP_RST_BIT];

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      loop_reset_out  <= 1'b0;
      lock_cnt        <= 12'h000;
      loop_locked_out <= 1'b1;
    end
    else
    begin
      loop_reset_out <= loop_rst_req;
      if (loop_rst_req)
      begin
        lock_cnt        <= 12'(LOCK_WAIT);
        loop_locked_out <= 1'b0;
      end
      else if (lock_cnt != 12'h000)
      begin
        lock_cnt        <= lock_cnt - 12'h001;
        loop_locked_out <= (lock_cnt == 12'h001);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // latencies and power-down exit

  // command register delay; read and write latency
  wire [3:0] rl_calc = 4'(added_latency_in) + 4'(fields.column_read_delay)
                     + 4'(CMD_REG_DELAY);
  wire [3:0] wl_calc = rl_calc - 4'h1;

  // exit variant, only in active power-down
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      read_latency_out      <= 4'h0;
      write_latency_out     <= 4'h0;
      column_read_delay_out <= RST_LAT;
      burst_eight_out       <= 1'b0;
      interleaved_out       <= 1'b0;
      slow_exit_out         <= 1'b0;
      loop_frozen_out       <= 1'b0;
    end
    else
    begin
      read_latency_out      <= rl_calc;
      write_latency_out     <= wl_calc;
      column_read_delay_out <= fields.column_read_delay;
      burst_eight_out       <= fields.burst_eight;
      interleaved_out       <= fields.interleaved;
      slow_exit_out         <= fields.slow_exit;
      loop_frozen_out       <= active_pd_in && fields.slow_exit;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read timing: held early read then data after latency

  logic [15:0] rd_pipe;
  logic [2:0]  al_cnt;
  logic        al_hold;
  // early read held for added latency
  wire al_issue  = al_hold && (al_cnt == 3'h1);
  wire rd_direct = read_cmd_in && !(early_read_in && added_latency_in != 0);
  wire rd_launch = rd_direct || al_issue;
  // data at column delay plus register delay after launch
  wire [3:0] rd_tap = 4'(fields.column_read_delay) + 4'(CMD_REG_DELAY) - 4'h1;

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      al_hold <= 1'b0;
      al_cnt  <= 3'h0;
    end
    else if (read_cmd_in && early_read_in && added_latency_in != 0)
    begin
      al_hold <= 1'b1;
      al_cnt  <= added_latency_in;
    end
    else if (al_hold)
    begin
      al_cnt  <= al_cnt - 3'h1;
      al_hold <= (al_cnt != 3'h1);
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      rd_pipe       <= '0;
      read_data_out <= 1'b0;
    end
    else
    begin
      rd_pipe       <= {rd_pipe[14:0], rd_launch};
      read_data_out <= rd_pipe[rd_tap];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // burst sequencing and write recovery

  logic [2:0] step;
  logic [2:0] start;
  logic       ap_pend;
  logic [3:0] wr_cnt;
  wire  [2:0] last_step = fields.burst_eight ? 3'h7 : 3'h3;
  wire        burst_go  = read_cmd_in || write_ap_cmd_in;
  wire  [2:0] step_nxt  = step + 3'h1;
  wire  [2:0] next_col;

  burst_order u_order (
    .start_in       (start),
    .step_in        (step_nxt),
    .burst_eight_in (fields.burst_eight),
    .interleaved_in (fields.interleaved),
    .col_out        (next_col)
  );

  // same length for read and write bursts
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      step             <= 3'h0;
      start            <= 3'h0;
      burst_active_out <= 1'b0;
      col_out          <= 3'h0;
    end
    else if (burst_go)
    begin
      start            <= col_start_in;
      step             <= 3'h0;
      burst_active_out <= 1'b1;
      col_out          <= col_start_in;
    end
    else if (burst_active_out)
    begin
      // step tracks the column on show; stop after the last one
      if (step == last_step)
        burst_active_out <= 1'b0;
      else
      begin
        col_out <= next_col;
        step    <= step_nxt;
      end
    end
  end

  // precharge recovery clocks after last data
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      ap_pend       <= 1'b0;
      wr_cnt        <= 4'h0;
      precharge_out <= 1'b0;
    end
    else
    begin
      precharge_out <= 1'b0;
      if (write_ap_cmd_in)
        ap_pend <= 1'b1;
      else if (ap_pend && burst_active_out && step == last_step)
      begin
        ap_pend <= 1'b0;
        wr_cnt  <= 4'(fields.recovery) - 4'h1; // one edge already spent
      end
      else if (wr_cnt != 4'h0)
      begin
        wr_cnt        <= wr_cnt - 4'h1;
        precharge_out <= (wr_cnt == 4'h1);
      end
    end
  end

endmodule

//--- shared/mode_cfg_pkg.sv
// shared constants and types for the mode-configuration register decode
package mode_cfg_pkg;

  // field positions inside the 15-bit mode word
  localparam int BURST_LSB     = 0;
  localparam int ORDER_BIT     = 3;
  localparam int LAT_LSB       = 4;
  localparam int TEST_BIT      = 7;
  localparam int LOOP_RST_BIT  = 8;
  localparam int REC_LSB       = 9;
  localparam int EXIT_BIT      = 12;
  localparam int MODE_W        = 15;
  localparam int BANK_W        = 3;

  // field codes
  localparam logic [2:0] BURST_CODE_4 = 3'h2;
  localparam logic [2:0] BURST_CODE_8 = 3'h3;
  localparam logic [2:0] LAT_MIN      = 3'h3;
  localparam logic [2:0] LAT_MAX      = 3'h5;
  localparam logic [2:0] REC_MIN      = 3'h2;
  localparam logic [2:0] REC_MAX      = 3'h6;

  // reset values (power-up defaults, safe legal settings)
  localparam logic [2:0] RST_LAT      = 3'h3;
  localparam logic [2:0] RST_REC      = 3'h2;

  // loop lock holdoff in clocks and command register delay
  localparam int LOCK_CYCLES   = 200;
  localparam int CMD_REG_DELAY = 1;

  // decoded mode settings carried as one bundle
  typedef struct packed {
    logic       burst_eight;   // 1: eight columns, 0: four
    logic       interleaved;   // ordering_bit
    logic [2:0] column_read_delay;
    logic [2:0] recovery;      // write recovery clocks
    logic       slow_exit;     // exit_speed_bit
  } mode_fields_t;

endpackage

//--- rtl/burst_order.sv
// column sequence generator for one burst step
`timescale 1ns/1ps
module burst_order
  import mode_cfg_pkg::*;
(
  input  wire logic [2:0] start_in,
  input  wire logic [2:0] step_in,
  input  wire logic       burst_eight_in,
  input  wire logic       interleaved_in,
  output logic      [2:0] col_out
);

  // sequential: low two bits rotate, nibble bit toggles after four
  wire [1:0] seq_low  = start_in[1:0] + step_in[1:0];
  wire       seq_hi   = start_in[2] ^ step_in[2];
  // interleaved: start xor counter
  wire [2:0] intl_col = start_in ^ step_in;
  wire [2:0] seq_col  = {seq_hi, seq_low};
  wire [2:0] sel_col  = interleaved_in ? intl_col : seq_col;

  // length four keeps the block bit from the start address
  assign col_out = burst_eight_in ? sel_col : {start_in[2], sel_col[1:0]};

endmodule

//--- tb/mode_config_decode_assertions.sv
// port-level checks for the mode-configuration decode
`timescale 1ns/1ps
module mode_config_decode_assertions
  import mode_cfg_pkg::*;
#(
  parameter int LOCK_WAIT = LOCK_CYCLES
)
(
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  input  wire logic              mode_set_command_in,
  input  wire logic [BANK_W-1:0] bank_in,
  input  wire logic [MODE_W-1:0] addr_in,
  input  wire logic [2:0]        added_latency_in,
  input  wire logic              read_cmd_in,
  input  wire logic              early_read_in,
  input  wire logic              active_pd_in,
  input  wire logic [MODE_W-1:0] load_mode_config_out,
  input  wire logic [2:0]        column_read_delay_out,
  input  wire logic [3:0]        read_latency_out,
  input  wire logic [3:0]        write_latency_out,
  input  wire logic              loop_reset_out,
  input  wire logic              loop_locked_out,
  input  wire logic              read_data_out,
  input  wire logic              test_mode_out,
  input  wire logic              slow_exit_out,
  input  wire logic              loop_frozen_out,
  input  wire logic              error_out
);
  logic sel;
  logic ok;
  // selected load and legal field codes
  assign sel = mode_set_command_in && (bank_in == '0);
  assign ok = (addr_in[2:0] == BURST_CODE_4 || addr_in[2:0] == BURST_CODE_8)
    && addr_in[6:4] >= LAT_MIN && addr_in[6:4] <= LAT_MAX
    && addr_in[11:9] >= 3'h1 && addr_in[11:9] <= 3'h5;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  property p_load;
    sel && !addr_in[7] && ok
      |=> load_mode_config_out == ($past(addr_in) & 15'h7eff);
  endproperty
  a_load: assert property (p_load) else $error("word not loaded");
  property p_bank;
    mode_set_command_in && bank_in != '0 |=> $stable(load_mode_config_out);
  endproperty
  a_bank: assert property (p_bank) else $error("bank ignored");
  property p_test;
    sel && addr_in[7] |=> test_mode_out && $stable(load_mode_config_out);
  endproperty
  a_test: assert property (p_test) else $error("test load");
  property p_err;
    sel && !addr_in[7] && !ok |=> error_out && $stable(load_mode_config_out);
  endproperty
  a_err: assert property (p_err) else $error("reserved load");
  property p_loop;
    sel && !addr_in[7] && ok && addr_in[8]
      |=> loop_reset_out && !loop_locked_out ##1 !loop_reset_out;
  endproperty
  a_loop: assert property (p_loop) else $error("loop reset pulse");
  property p_wl;
    read_latency_out != 4'h0 |-> write_latency_out == read_latency_out - 4'h1;
  endproperty
  a_wl: assert property (p_wl) else $error("write latency");
  property p_rd;
    read_cmd_in && !early_read_in && added_latency_in == 3'h0
      && column_read_delay_out == 3'h3 |-> ##[4:5] read_data_out;
  endproperty
  a_rd: assert property (p_rd) else $error("read data late");
  property p_frz;
    (active_pd_in && slow_exit_out) [*2] |=> loop_frozen_out;
  endproperty
  a_frz: assert property (p_frz) else $error("loop not frozen");
  property p_pre;
    !active_pd_in |=> !loop_frozen_out;
  endproperty
  a_pre: assert property (p_pre) else $error("frozen outside");
endmodule
bind mode_config_decode mode_config_decode_assertions
  #(.LOCK_WAIT(LOCK_WAIT)) chk (.clk_in, .resetn_in, .mode_set_command_in,
  .bank_in, .addr_in, .added_latency_in, .read_cmd_in, .early_read_in,
  .active_pd_in, .load_mode_config_out, .column_read_delay_out,
  .read_latency_out, .write_latency_out, .loop_reset_out, .loop_locked_out,
  .read_data_out, .test_mode_out, .slow_exit_out, .loop_frozen_out,
  .error_out);

//--- tb/ctrl_model.sv
// controller-side model issuing mode_set_command cycles
`timescale 1ns/1ps
module ctrl_model
  import mode_cfg_pkg::*;
#(
  parameter int GAP = 2
)
(
  input  wire logic              clk_in,
  input  wire logic              go_in,
  input  wire logic [BANK_W-1:0] bank_sel_in,
  input  wire logic [MODE_W-1:0] word_in,
  output logic                   mode_set_command_out,
  output logic      [BANK_W-1:0] bank_out,
  output logic      [MODE_W-1:0] addr_out
);
  int gap_left = 0;
  // idle bus levels at start
  initial
  begin
    mode_set_command_out = 1'b0;
    bank_out = '0;
    addr_out = '0;
  end
  always @(negedge clk_in)
  begin
    if (go_in && gap_left == 0)
    begin
      mode_set_command_out <= 1'b1;
      bank_out             <= bank_sel_in;
      addr_out             <= word_in;
      gap_left             <= GAP;
    end
    else
    begin
      mode_set_command_out <= 1'b0;
      bank_out             <= ~bank_out;
      addr_out             <= ~addr_out;
      gap_left             <= (gap_left != 0) ? gap_left - 1 : 0;
    end
  end
endmodule

//--- tb/mode_config_decode_tb.sv
// self-checking bench for the mode-configuration decode
`timescale 1ns/1ps
module mode_config_decode_tb
  import mode_cfg_pkg::*;
;
  localparam int LW = 5;
  logic              clk_in = 1'b0;
  logic              resetn_in = 1'b0;
  logic              go = 1'b0;
  logic [BANK_W-1:0] bsel = '0;
  logic [MODE_W-1:0] word = '0;
  logic [MODE_W-1:0] w;
  logic [MODE_W-1:0] badw [4];
  logic [BANK_W-1:0] bank;
  logic [MODE_W-1:0] addr;
  logic [MODE_W-1:0] cfg;
  logic [2:0]        al = '0;
  logic [2:0]        cs = '0;
  logic [2:0]        crd;
  logic [2:0]        col;
  logic [3:0]        rl;
  logic [3:0]        wl;
  logic              cmd, rd = 0, wr = 0, er = 0, apd = 0, b8, il, sl;
  logic              b8o, ilo, act, lrst, lck, rdat, pre, tm, slo, frz, err;
  int                cl, rc, aln, n;
  int                bad_count = 0;
  int                n_tests = 0;
  integer            seed = 42166;
  // 20 MHz clock
  always #25 clk_in = ~clk_in;
  ctrl_model ctl (.clk_in(clk_in), .go_in(go), .bank_sel_in(bsel),
    .word_in(word), .mode_set_command_out(cmd), .bank_out(bank),
    .addr_out(addr));
  mode_config_decode #(.LOCK_WAIT(LW)) uut (.clk_in(clk_in),
    .resetn_in(resetn_in), .mode_set_command_in(cmd), .bank_in(bank),
    .addr_in(addr), .added_latency_in(al), .read_cmd_in(rd),
    .write_ap_cmd_in(wr), .early_read_in(er), .col_start_in(cs),
    .active_pd_in(apd), .load_mode_config_out(cfg),
    .column_read_delay_out(crd), .read_latency_out(rl),
    .write_latency_out(wl), .burst_eight_out(b8o), .interleaved_out(ilo),
    .col_out(col), .burst_active_out(act), .loop_reset_out(lrst),
    .loop_locked_out(lck), .read_data_out(rdat), .precharge_out(pre),
    .test_mode_out(tm), .slow_exit_out(slo), .loop_frozen_out(frz),
    .error_out(err));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    n_tests++;
    if (e !== s)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // legal word from the current field choices
  function automatic logic [14:0] mk();
    return {2'h0, sl, 3'(rc), 2'h0, 3'(cl), il,
      b8 ? BURST_CODE_8 : BURST_CODE_4};
  endfunction
  // expected column of step k
  function automatic logic [2:0] xcol(logic [2:0] s, int k);
    logic [2:0] q;
    q = 3'(k);
    return il ? s ^ q : {s[2] ^ q[2], s[1:0] + q[1:0]};
  endfunction
  task automatic load(logic [2:0] bk, logic [14:0] v);
    @(negedge clk_in);
    go <= 1'b1;
    bsel <= bk;
    word <= v;
    @(negedge clk_in);
    go <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
  endtask
  // one burst command, then column, data and precharge timing
  task automatic op(logic wo, logic [2:0] s, logic e);
    int k;
    int lc;
    int ri;
    int pi;
    k = 0;
    lc = 0;
    ri = 0;
    pi = 0;
    @(negedge clk_in);
    rd <= !wo;
    wr <= wo;
    cs <= s;
    er <= e;
    for (int i = 0; i < 32; i++)
    begin
      @(posedge clk_in);
      #1;
      if (act && !e)
      begin
        chk("col", 16'(xcol(s, k)), 16'(col));
        k++;
        lc = i;
      end
      ri = (rdat && ri == 0) ? i : ri;
      pi = (pre && pi == 0) ? i : pi;
      @(negedge clk_in);
      rd <= 1'b0;
      wr <= 1'b0;
    end
    if (!e) chk("len", 16'(b8 ? 8 : 4), 16'(k));
    if (!wo) chk("rdlat", 16'(cl + 1 + (e ? aln : 0)), 16'(ri));
    else chk("prech", 16'(rc + 1), 16'(pi - lc));
  endtask
  //////////////////////////////////////////////////////////////////////////
  // main sequence: random legal words, then refusals and side effects
  initial
  begin
    repeat (2) @(negedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    #1;
    chk("crd0", 16'h3, 16'(crd));
    chk("lock0", 16'h1, 16'(lck));
    for (int t = 0; t < 16; t++)
    begin
      b8 = 1'($random(seed));
      il = 1'($random(seed));
      sl = 1'($random(seed));
      cl = (t == 0) ? 5 : (t == 1) ? 3 : 3 + $unsigned($random(seed)) % 3;
      rc = (t == 0) ? 5 : 1 + $unsigned($random(seed)) % 5;
      aln = (t == 1) ? 0 : $unsigned($random(seed)) % 5;
      @(negedge clk_in);
      al <= 3'(aln);
      w = mk();
      load(3'h0, w);
      chk("cfg", 16'(w), 16'(cfg));
      chk("fld", 16'({b8, il, sl, 3'(cl)}), 16'({b8o, ilo, slo, crd}));
      chk("rl", 16'(aln + cl + 1), 16'(rl));
      chk("wl", 16'(aln + cl), 16'(wl));
      op(1'b0, 3'($random(seed)), 1'b0);
      op(1'b1, 3'($random(seed)), 1'b0);
      op(1'b0, 3'($random(seed)), aln != 0);
    end
    load(3'h0, w | 15'h0080);
    chk("tm", 16'h1, 16'(tm));
    chk("tmcfg", 16'(w), 16'(cfg));
    badw = '{w & 15'h7ff8, (w & 15'h7f8f) | 15'h0020, w & 15'h71ff,
      w | 15'h0e00};
    foreach (badw[i])
    begin
      load(3'h0, badw[i]);
      chk("err", 16'h1, 16'(err));
      chk("errcfg", 16'(w), 16'(cfg));
    end
    load(3'h1, w ^ 15'h0008);
    chk("bank", 16'(w), 16'(cfg));
    load(3'h0, w | 15'h0100);
    chk("selfclr", 16'(w), 16'(cfg));
    n = 0;
    while (lck !== 1'b1 && n < 50)
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    // load returns two edges after the strobe edge
    chk("lock", 16'(LW - 2), 16'(n));
    op(1'b0, 3'h5, 1'b0);
    load(3'h0, w | 15'h1000);
    @(negedge clk_in);
    apd <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    chk("frozen", 16'h1, 16'(frz));
    @(negedge clk_in);
    apd <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    chk("thawed", 16'h0, 16'(frz));
    // fast exit keeps the loop running in active power-down
    load(3'h0, w & 15'h6fff);
    @(negedge clk_in);
    apd <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    chk("fastrun", 16'h0, 16'(frz));
    @(negedge clk_in);
    apd <= 1'b0;
    print_verdict();
  end
endmodule
